// file: common/ifr_pkg.sv
// Constants shared by the input function router
package ifr_pkg;
  // ============================================================
  // Sizes
  localparam int NUM_LINES = 16;
  localparam int NUM_CH = 2;
  localparam int SYNC_STAGES = 2;
  // ============================================================
  // Line index of each function for channel or axis 0; add the index (twice the index for A/B)
  localparam int LN_A_BASE = 0;
  localparam int LN_AB_STEP = 2;
  localparam int LN_Z_BASE = 4;
  localparam int LN_FUNC_BASE = 6;
  localparam int LN_LATCH_BASE = 8;
  localparam int LN_DOG_BASE = 10;
  localparam int LN_UPPER_BASE = 12;
  localparam int LN_LOWER_BASE = 14;
  // ============================================================
  // Reset values
  localparam logic [NUM_CH-1:0] CH_RST = 2'h0;
  localparam logic [NUM_LINES-1:0] LINES_RST = 16'h0000;
endpackage : ifr_pkg

// file: rtl/ifr_sync.sv
// Two-stage synchroniser for a bus of asynchronous pin levels
`timescale 1ns/1ps
module ifr_sync #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // The first stage is read only by the second stage
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : ifr_sync

// file: rtl/ifr_router.sv
// Routes sixteen input lines to general, interrupt, counter and axis users
// Behaviour
// - every line reaches general, interrupt, pulse catch
// - lines 0-3 give counter A/B phases
// - counter 1 enabled blocks interrupts on 0,1
// - counter 2 enabled blocks interrupts on 2,3
// - lines 4,5 give Z phase or zero
// - lines 6,7 give function input or command
// - lines 8,9 give latch trigger or ready
// - lines 10,11 give near-point dog
// - lines 12-15 give upper and lower limits
// - 0-3 never positioning, 10-15 never counters
// - unused function inputs are released to general use
`timescale 1ns/1ps
module ifr_router #(
  parameter int NUM_LINES = ifr_pkg::NUM_LINES,
  parameter int NUM_CH = ifr_pkg::NUM_CH
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [NUM_LINES-1:0] in_line,
  input wire logic cfg_load,
  input wire logic [NUM_CH-1:0] cfg_cnt_en,
  input wire logic [NUM_CH-1:0] cfg_pos_en,
  input wire logic [NUM_CH-1:0] cfg_use_z,
  input wire logic [NUM_CH-1:0] cfg_use_func,
  input wire logic [NUM_CH-1:0] cfg_use_latch,
  input wire logic [NUM_CH-1:0] cfg_use_dog,
  input wire logic [NUM_CH-1:0] cfg_use_limits,
  input wire logic [NUM_LINES-1:0] cfg_irq_en,
  input wire logic [NUM_LINES-1:0] cfg_pcatch_en,
  output logic [NUM_LINES-1:0] gp_in_q,
  output logic [NUM_LINES-1:0] irq_in_q,
  output logic [NUM_LINES-1:0] pcatch_in_q,
  output logic [NUM_LINES-1:0] line_claimed_q,
  output logic [NUM_CH-1:0] counter_chan_a_q,
  output logic [NUM_CH-1:0] counter_chan_b_q,
  output logic [NUM_CH-1:0] counter_chan_z_q,
  output logic [NUM_CH-1:0] counter_chan_func_q,
  output logic [NUM_CH-1:0] counter_chan_latch_q,
  output logic [NUM_CH-1:0] axis_zero_q,
  output logic [NUM_CH-1:0] axis_cmd_q,
  output logic [NUM_CH-1:0] axis_ready_q,
  output logic [NUM_CH-1:0] axis_dog_q,
  output logic [NUM_CH-1:0] axis_upper_q,
  output logic [NUM_CH-1:0] axis_lower_q
);
  // ============================================================
  // Pin synchronisers
  logic [NUM_LINES-1:0] line_s;

  ifr_sync #(
    .WIDTH(NUM_LINES)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(in_line),
    .sync_out(line_s)
  );

  // ============================================================
  // Static configuration
  // Held apart from the live config ports so that a routing change only
  // happens on an explicit load, never while software edits fields.
  logic [NUM_CH-1:0] cnt_en_q, cnt_en_d;
  logic [NUM_CH-1:0] pos_en_q, pos_en_d;
  logic [NUM_CH-1:0] use_z_q, use_z_d;
  logic [NUM_CH-1:0] use_func_q, use_func_d;
  logic [NUM_CH-1:0] use_latch_q, use_latch_d;
  logic [NUM_CH-1:0] use_dog_q, use_dog_d;
  logic [NUM_CH-1:0] use_lim_q, use_lim_d;
  logic [NUM_LINES-1:0] irq_en_q, irq_en_d;
  logic [NUM_LINES-1:0] pc_en_q, pc_en_d;

  assign cnt_en_d = cfg_load ? cfg_cnt_en : cnt_en_q;
  assign pos_en_d = cfg_load ? cfg_pos_en : pos_en_q;
  assign use_z_d = cfg_load ? cfg_use_z : use_z_q;
  assign use_func_d = cfg_load ? cfg_use_func : use_func_q;
  assign use_latch_d = cfg_load ? cfg_use_latch : use_latch_q;
  assign use_dog_d = cfg_load ? cfg_use_dog : use_dog_q;
  assign use_lim_d = cfg_load ? cfg_use_limits : use_lim_q;
  assign irq_en_d = cfg_load ? cfg_irq_en : irq_en_q;
  assign pc_en_d = cfg_load ? cfg_pcatch_en : pc_en_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_en_q <= ifr_pkg::CH_RST;
      pos_en_q <= ifr_pkg::CH_RST;
      use_z_q <= ifr_pkg::CH_RST;
      use_func_q <= ifr_pkg::CH_RST;
      use_latch_q <= ifr_pkg::CH_RST;
      use_dog_q <= ifr_pkg::CH_RST;
      use_lim_q <= ifr_pkg::CH_RST;
      irq_en_q <= ifr_pkg::LINES_RST;
      pc_en_q <= ifr_pkg::LINES_RST;
    end else if (clk_en) begin
      cnt_en_q <= cnt_en_d;
      pos_en_q <= pos_en_d;
      use_z_q <= use_z_d;
      use_func_q <= use_func_d;
      use_latch_q <= use_latch_d;
      use_dog_q <= use_dog_d;
      use_lim_q <= use_lim_d;
      irq_en_q <= irq_en_d;
      pc_en_q <= pc_en_d;
    end
  end

  // ============================================================
  // Per channel and axis routing
  // Lines 4 to 9 are shared; when both are set, positioning owns them
  // and the counter keeps only its A/B phases.
  logic [NUM_CH-1:0] cnt_own;
  logic [NUM_CH-1:0] pos_own;
  logic [NUM_CH-1:0] a_d, b_d, z_d, func_d, latch_d;
  logic [NUM_CH-1:0] zero_d, cmd_d, rdy_d, dog_d, upper_d, lower_d;
  logic [NUM_LINES-1:0] claim_d;
  logic [NUM_LINES-1:0] irq_blk;

  genvar k;
  generate
    for (k = 0; k < NUM_CH; k++) begin : g_ch
      localparam int LA = ifr_pkg::LN_A_BASE + k * ifr_pkg::LN_AB_STEP;
      localparam int LZ = ifr_pkg::LN_Z_BASE + k;
      localparam int LF = ifr_pkg::LN_FUNC_BASE + k;
      localparam int LL = ifr_pkg::LN_LATCH_BASE + k;
      localparam int LD = ifr_pkg::LN_DOG_BASE + k;
      localparam int LU = ifr_pkg::LN_UPPER_BASE + k;
      localparam int LW = ifr_pkg::LN_LOWER_BASE + k;
      wire cnt_sh = cnt_en_q[k] & ~pos_en_q[k];

      assign cnt_own[k] = cnt_sh;
      assign pos_own[k] = pos_en_q[k];
      // Counter phases come only from the low lines
      assign a_d[k] = cnt_en_q[k] & line_s[LA];
      assign b_d[k] = cnt_en_q[k] & line_s[LA+1];
      assign z_d[k] = cnt_sh & use_z_q[k] & line_s[LZ];
      assign func_d[k] = cnt_sh & use_func_q[k] & line_s[LF];
      assign latch_d[k] = cnt_sh & use_latch_q[k] & line_s[LL];
      assign zero_d[k] = pos_en_q[k] & use_z_q[k] & line_s[LZ];
      assign cmd_d[k] = pos_en_q[k] & use_func_q[k] & line_s[LF];
      assign rdy_d[k] = pos_en_q[k] & use_latch_q[k] & line_s[LL];
      assign dog_d[k] = pos_en_q[k] & use_dog_q[k] & line_s[LD];
      assign upper_d[k] = pos_en_q[k] & use_lim_q[k] & line_s[LU];
      assign lower_d[k] = pos_en_q[k] & use_lim_q[k] & line_s[LW];
      // A/B lines never claimed by positioning, high lines never by counters
      assign claim_d[LA] = cnt_en_q[k];
      assign claim_d[LA+1] = cnt_en_q[k];
      assign claim_d[LZ] = (cnt_en_q[k] | pos_en_q[k]) & use_z_q[k];
      assign claim_d[LF] = (cnt_en_q[k] | pos_en_q[k]) & use_func_q[k];
      assign claim_d[LL] = (cnt_en_q[k] | pos_en_q[k]) & use_latch_q[k];
      assign claim_d[LD] = pos_en_q[k] & use_dog_q[k];
      assign claim_d[LU] = pos_en_q[k] & use_lim_q[k];
      assign claim_d[LW] = pos_en_q[k] & use_lim_q[k];
      // An enabled counter takes its A/B lines away from interrupts only
      assign irq_blk[LA] = cnt_en_q[k];
      assign irq_blk[LA+1] = cnt_en_q[k];
      assign irq_blk[LZ] = 1'b0;
      assign irq_blk[LF] = 1'b0;
      assign irq_blk[LL] = 1'b0;
      assign irq_blk[LD] = 1'b0;
      assign irq_blk[LU] = 1'b0;
      assign irq_blk[LW] = 1'b0;
    end
  endgenerate

  // General input always mirrors every line, claimed or not
  wire [NUM_LINES-1:0] gp_d = line_s;
  wire [NUM_LINES-1:0] irq_d = line_s & irq_en_q & ~irq_blk;
  wire [NUM_LINES-1:0] pc_d = line_s & pc_en_q;

  // ============================================================
  // Registered outputs
  // Every routed output leaves a flop, so a config load cannot glitch them.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gp_in_q <= ifr_pkg::LINES_RST;
      irq_in_q <= ifr_pkg::LINES_RST;
      pcatch_in_q <= ifr_pkg::LINES_RST;
      line_claimed_q <= ifr_pkg::LINES_RST;
    end else if (clk_en) begin
      gp_in_q <= gp_d;
      irq_in_q <= irq_d;
      pcatch_in_q <= pc_d;
      line_claimed_q <= claim_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      counter_chan_a_q <= ifr_pkg::CH_RST;
      counter_chan_b_q <= ifr_pkg::CH_RST;
      counter_chan_z_q <= ifr_pkg::CH_RST;
      counter_chan_func_q <= ifr_pkg::CH_RST;
      counter_chan_latch_q <= ifr_pkg::CH_RST;
    end else if (clk_en) begin
      counter_chan_a_q <= a_d;
      counter_chan_b_q <= b_d;
      counter_chan_z_q <= z_d;
      counter_chan_func_q <= func_d;
      counter_chan_latch_q <= latch_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      axis_zero_q <= ifr_pkg::CH_RST;
      axis_cmd_q <= ifr_pkg::CH_RST;
      axis_ready_q <= ifr_pkg::CH_RST;
      axis_dog_q <= ifr_pkg::CH_RST;
      axis_upper_q <= ifr_pkg::CH_RST;
      axis_lower_q <= ifr_pkg::CH_RST;
    end else if (clk_en) begin
      axis_zero_q <= zero_d;
      axis_cmd_q <= cmd_d;
      axis_ready_q <= rdy_d;
      axis_dog_q <= dog_d;
      axis_upper_q <= upper_d;
      axis_lower_q <= lower_d;
    end
  end
endmodule : ifr_router

// file: tb/ifr_sensors.sv
// Sensor, encoder and drive-signal model feeding the raw input lines
`timescale 1ns/1ps
module ifr_sensors (
  input wire logic sys_clk,
  input wire logic [15:0] level,
  output logic [15:0] in_line
);
  // Levels move 1 ns after each rising edge of the sampling clock
  initial in_line = 16'h0000;
  always @(posedge sys_clk) in_line <= #1 level;
endmodule : ifr_sensors

// file: tb/ifr_router_checker.sv
// Concurrent checks on the ports of the input function router
`timescale 1ns/1ps
module ifr_router_checker #(
  parameter int NUM_LINES = 16,
  parameter int NUM_CH = 2
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [NUM_LINES-1:0] in_line,
  input wire logic cfg_load,
  input wire logic [NUM_LINES-1:0] gp_in_q,
  input wire logic [NUM_LINES-1:0] irq_in_q,
  input wire logic [NUM_LINES-1:0] pcatch_in_q,
  input wire logic [NUM_LINES-1:0] line_claimed_q,
  input wire logic [NUM_CH-1:0] counter_chan_a_q,
  input wire logic [NUM_CH-1:0] counter_chan_b_q,
  input wire logic [NUM_CH-1:0] counter_chan_z_q,
  input wire logic [NUM_CH-1:0] counter_chan_func_q,
  input wire logic [NUM_CH-1:0] counter_chan_latch_q,
  input wire logic [NUM_CH-1:0] axis_zero_q,
  input wire logic [NUM_CH-1:0] axis_cmd_q,
  input wire logic [NUM_CH-1:0] axis_ready_q,
  input wire logic [NUM_CH-1:0] axis_dog_q,
  input wire logic [NUM_CH-1:0] axis_upper_q,
  input wire logic [NUM_CH-1:0] axis_lower_q
);
  // ============================================================
  // Run length since reset or clock enable low; the pipeline needs three clean edges
  logic [1:0] run_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn || !clk_en) run_q <= 2'h0;
    else if (run_q != 2'h3) run_q <= run_q + 2'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  gp_follow_a: assert property (
    run_q == 2'h3 |-> gp_in_q == $past(in_line, 3))
    else $error("line level not seen after three edges");
  user_subset_a: assert property (
    ((irq_in_q | pcatch_in_q) & ~gp_in_q) == 16'h0000)
    else $error("interrupt or catch without line level");
  phase_sub_a: assert property (
    ({counter_chan_b_q[1], counter_chan_a_q[1], counter_chan_b_q[0],
      counter_chan_a_q[0]} & ~gp_in_q[3:0]) == 4'h0)
    else $error("phase output without its line");
  irq_blk1_a: assert property (
    |{counter_chan_a_q[0], counter_chan_b_q[0]} |-> irq_in_q[1:0] == 2'h0)
    else $error("interrupt on lines 0 1 with counter 1 on");
  irq_blk2_a: assert property (
    |{counter_chan_a_q[1], counter_chan_b_q[1]} |-> irq_in_q[3:2] == 2'h0)
    else $error("interrupt on lines 2 3 with counter 2 on");
  z_excl_a: assert property (
    (counter_chan_z_q & axis_zero_q) == 2'h0)
    else $error("z phase and axis zero both driven");
  shared_excl_a: assert property (
    ((counter_chan_func_q & axis_cmd_q) |
     (counter_chan_latch_q & axis_ready_q)) == 2'h0)
    else $error("shared line routed to both users");
  dog_lim_a: assert property (
    ({axis_lower_q, axis_upper_q, axis_dog_q} & ~gp_in_q[15:10]) == 6'h00)
    else $error("dog or limit without its line");
  cfg_hold_a: assert property (
    run_q == 2'h3 && !$past(cfg_load, 2) |-> $stable(line_claimed_q))
    else $error("ownership moved without a load");
  cover property (counter_chan_a_q[0]);
  cover property (axis_dog_q != 2'h0);
  cover property (irq_in_q != 16'h0000);
  cover property (!clk_en ##1 clk_en);
endmodule : ifr_router_checker
bind ifr_router ifr_router_checker #(
  .NUM_LINES(NUM_LINES), .NUM_CH(NUM_CH)) chk (
  .sys_clk, .resetn, .clk_en, .in_line, .cfg_load, .gp_in_q, .irq_in_q,
  .pcatch_in_q, .line_claimed_q, .counter_chan_a_q, .counter_chan_b_q,
  .counter_chan_z_q, .counter_chan_func_q, .counter_chan_latch_q,
  .axis_zero_q, .axis_cmd_q, .axis_ready_q, .axis_dog_q, .axis_upper_q,
  .axis_lower_q);

// file: tb/tb.sv
// Self-checking bench for the input function router
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_load = 1'b0;
  logic [1:0] cnt, pos, uz, uf, ul, ud, um;
  logic [15:0] ien, pen, level, rnd, in_line;
  wire [85:0] got;
  logic [85:0] last_exp;
  logic clk_en = 1'b1;
  logic [85:0] exp_q[$];
  int chk_q[$];
  int cyc = 0;
  int mismatches = 0;
  int total_checks = 0;
  always #4 sys_clk = ~sys_clk;
  ifr_sensors sensors (.sys_clk(sys_clk), .level(level), .in_line(in_line));
  ifr_router dut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .in_line(in_line),
    .cfg_load(cfg_load), .cfg_cnt_en(cnt), .cfg_pos_en(pos),
    .cfg_use_z(uz), .cfg_use_func(uf), .cfg_use_latch(ul),
    .cfg_use_dog(ud), .cfg_use_limits(um), .cfg_irq_en(ien),
    .cfg_pcatch_en(pen), .gp_in_q(got[85:70]), .irq_in_q(got[69:54]),
    .pcatch_in_q(got[53:38]), .line_claimed_q(got[37:22]),
    .counter_chan_a_q(got[21:20]), .counter_chan_b_q(got[19:18]),
    .counter_chan_z_q(got[17:16]), .counter_chan_func_q(got[15:14]),
    .counter_chan_latch_q(got[13:12]), .axis_zero_q(got[11:10]),
    .axis_cmd_q(got[9:8]), .axis_ready_q(got[7:6]),
    .axis_dog_q(got[5:4]), .axis_upper_q(got[3:2]), .axis_lower_q(got[1:0]));
  // ============================================================
  // Reference routing, built from the held configuration
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [85:0] model(input logic [15:0] l);
    logic [15:0] ir, clm, m;
    ir = l & ien;
    for (int k = 0; k < 2; k++) begin
      if (cnt[k]) ir[2*k +: 2] = 2'h0;
      clm[2*k +: 2] = {2{cnt[k]}};
      clm[4+k] = (cnt[k] | pos[k]) & uz[k];
      clm[6+k] = (cnt[k] | pos[k]) & uf[k];
      clm[8+k] = (cnt[k] | pos[k]) & ul[k];
      clm[10+k] = pos[k] & ud[k];
      clm[12+k] = pos[k] & um[k];
      clm[14+k] = pos[k] & um[k];
    end
    m = l & clm;
    return {l, ir, l & pen, clm, m[2], m[0], m[3], m[1],
      m[5:4] & ~pos, m[7:6] & ~pos, m[9:8] & ~pos, m[5:4] & pos,
      m[7:6] & pos, m[9:8] & pos, m[11:10], m[13:12], m[15:14]};
  endfunction : model
  // ============================================================
  // Driver: load, then scramble the unloaded fields, which must be ignored
  task automatic step();
    @(posedge sys_clk);
    rnd = lfsr(lfsr(rnd));
    {cnt, pos, uz, uf, ul, ud, um} <= rnd[13:0];
    ien <= lfsr(rnd);
    pen <= lfsr(lfsr(rnd));
    level <= lfsr(lfsr(lfsr(rnd)));
    cfg_load <= 1'b1;
    @(posedge sys_clk);
    last_exp = model(level);
    exp_q.push_back(last_exp);
    chk_q.push_back(cyc + 4);
    cfg_load <= 1'b0;
    {cnt, pos, uz, uf, ul, ud, um} <= ~rnd[15:2];
    ien <= ~ien;
    pen <= ~pen;
    repeat (3) @(posedge sys_clk);
  endtask : step
  // ============================================================
  // Clock enable low must hold every output while the pins move
  task automatic freeze();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    level <= ~level;
    @(posedge sys_clk);
    exp_q.push_back(last_exp);
    chk_q.push_back(cyc + 3);
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
  endtask : freeze
  task automatic check(input string what, input logic [85:0] e,
                       input logic [85:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : check
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (chk_q.size() > 0 && chk_q[0] == cyc) begin
      void'(chk_q.pop_front());
      check("routed outputs", exp_q.pop_front(), got);
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    rnd = 16'h0040;
    {cnt, pos, uz, uf, ul, ud, um} = 14'h0000;
    {ien, pen, level} = 48'h0000_0000_0000;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int n = 0; n < 400; n++) begin
      step();
      if (n % 8 == 7) freeze();
    end
    for (int i = 0; i < 20 && chk_q.size() > 0; i++) @(posedge sys_clk);
    if (chk_q.size() > 0) mismatches++;
    $display("random routing test finished");
    tally_and_finish();
  end
endmodule : tb
